// ### design/pin_sync_edge.v
`timescale 1ns/100ps
// two-flop synchroniser with edge detection on the synchronised level
module pin_sync_edge (
  input  wire clk_i,
  input  wire rstn_i,
  input  wire pin_i,
  output reg  level_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta_reg;   // first stage, read only by the second
  reg prev_reg;   // previous synchronised level

  // synchronise and keep one cycle of history
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= 1'b0;
      level_o  <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      level_o  <= meta_reg;
      prev_reg <= level_o;
    end
  end

  assign rise_o = level_o & ~prev_reg;
  assign fall_o = ~level_o & prev_reg;

endmodule // pin_sync_edge

// ### design/timer_channel_map.vh
`ifndef TIMER_CHANNEL_MAP_VH
`define TIMER_CHANNEL_MAP_VH

// register byte offsets
`define OFS_CONTROL        8'h00
`define OFS_CHANNEL_MODE   8'h04
`define OFS_COUNT          8'h10
`define OFS_FIRST_CAPTURE  8'h14
`define OFS_SECOND_CAPTURE 8'h18
`define OFS_LIMIT          8'h1c
`define OFS_STATUS         8'h20

// reset values
`define RST_CHANNEL_MODE   32'h0000_0000
`define RST_VALUE          16'h0000

// control command bits (write only)
`define CTL_CLK_ENABLE     0
`define CTL_CLK_DISABLE    1
`define CTL_SW_TRIGGER     2

// channel mode fields, common except trigger and event source bits 10 to 12
`define FLD_CLK_SEL_LO     0
`define FLD_CLK_INVERT     3
`define FLD_BURST_LO       4
`define FLD_STOP           6
`define FLD_DISABLE        7
`define FLD_EDGE_LO        8
`define FLD_TRIG_SRC       10
`define FLD_EVT_SRC_LO     10
`define FLD_EVT_RESTART    12
`define FLD_LIMIT_RESTART  14
`define FLD_WAVE           15
// capture loads
`define FLD_FIRST_LD_LO    16
`define FLD_SECOND_LD_LO   18
// waveform actions on line a and line b
`define FLD_A_MATCH_LO     16
`define FLD_A_LIMIT_LO     18
`define FLD_A_EVENT_LO     20
`define FLD_A_SWTRIG_LO    22
`define FLD_B_MATCH_LO     24
`define FLD_B_LIMIT_LO     26
`define FLD_B_EVENT_LO     28
`define FLD_B_SWTRIG_LO    30

// status bits
`define STS_CLK_ENABLED    0
`define STS_CLK_RUNNING    1
`define STS_LINE_A         2
`define STS_LINE_B         3
`define STS_WAVE           4

// prescaler tap positions for master clock /2, /8, /32, /128, /1024
`define TAP_DIV2           0
`define TAP_DIV8           2
`define TAP_DIV32          4
`define TAP_DIV128         6
`define TAP_DIV1024        9
`define PRESCALE_WIDTH     10

`endif

// ### design/timer_channel_mode_control.v
`timescale 1ns/100ps
`include "timer_channel_map.vh"

module timer_channel_mode_control #(
  parameter CNT_WIDTH = 16
) (
  input  wire        SYS_CLK_I,
  input  wire        RSTN_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  input  wire        EXT_CLK_SIG_ZERO_I,
  input  wire        EXT_CLK_SIG_ONE_I,
  input  wire        EXT_CLK_SIG_TWO_I,
  input  wire        IO_LINE_A_I,
  output reg         IO_LINE_A_O,
  output reg         IO_LINE_A_OE_O,
  input  wire        IO_LINE_B_I,
  output reg         IO_LINE_B_O,
  output reg         IO_LINE_B_OE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // edge field: bit0 takes rising, bit1 takes falling
  function edge_hit;
    input [1:0] code;
    input       rise;
    input       fall;
    begin
      edge_hit = (code[0] & rise) | (code[1] & fall);
    end
  endfunction

  // output action: 0 keep, 1 set, 2 clear, 3 toggle
  function apply_action;
    input [1:0] code;
    input       cur;
    begin
      case (code)
        2'd1:    apply_action = 1'b1;
        2'd2:    apply_action = 1'b0;
        2'd3:    apply_action = ~cur;
        default: apply_action = cur;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [31:0]               channel_mode_reg;     // mode register
  reg  [CNT_WIDTH-1:0]      count_reg;            // counter value
  reg  [CNT_WIDTH-1:0]      first_capture_reg;    // capture / compare a
  reg  [CNT_WIDTH-1:0]      second_capture_reg;   // capture / compare b
  reg  [CNT_WIDTH-1:0]      limit_reg;            // limit value
  reg  [`PRESCALE_WIDTH-1:0] prescale_reg;        // master clock divider
  reg                       clk_enabled_reg;      // clock enabled by software
  reg                       clk_running_reg;      // clock started by trigger
  reg                       gated_prev_reg;       // last gated clock level
  reg  [CNT_WIDTH-1:0]      count_next;
  reg                       running_next;
  reg                       enabled_next;
  reg                       line_a_next;
  reg                       line_b_next;
  reg                       tap_level;            // selected clock level
  reg                       burst_level;          // gating signal level
  reg                       evt_rise;             // selected event edges
  reg                       evt_fall;
  reg  [31:0]               rd_data;

  wire ext0_lvl, ext0_rise, ext0_fall;
  wire ext1_lvl, ext1_rise, ext1_fall;
  wire ext2_lvl, ext2_rise, ext2_fall;
  wire la_lvl,  la_rise,  la_fall;
  wire lb_lvl,  lb_rise,  lb_fall;

  // mode fields
  wire [2:0] count_clock_select  = channel_mode_reg[`FLD_CLK_SEL_LO+2:`FLD_CLK_SEL_LO];
  wire       count_edge_invert   = channel_mode_reg[`FLD_CLK_INVERT];
  wire [1:0] burst_select        = channel_mode_reg[`FLD_BURST_LO+1:`FLD_BURST_LO];
  wire       stop_bit            = channel_mode_reg[`FLD_STOP];
  wire       disable_bit         = channel_mode_reg[`FLD_DISABLE];
  wire [1:0] edge_select         = channel_mode_reg[`FLD_EDGE_LO+1:`FLD_EDGE_LO];
  wire       trigger_source_select = channel_mode_reg[`FLD_TRIG_SRC];
  wire [1:0] event_source_select = channel_mode_reg[`FLD_EVT_SRC_LO+1:`FLD_EVT_SRC_LO];
  wire       event_restart_en    = channel_mode_reg[`FLD_EVT_RESTART];
  wire       limit_match_restart_en = channel_mode_reg[`FLD_LIMIT_RESTART];
  wire       wave                = channel_mode_reg[`FLD_WAVE];
  wire [1:0] first_capture_edge_sel  = channel_mode_reg[`FLD_FIRST_LD_LO+1:`FLD_FIRST_LD_LO];
  wire [1:0] second_capture_edge_sel = channel_mode_reg[`FLD_SECOND_LD_LO+1:`FLD_SECOND_LD_LO];
  wire [1:0] line_a_on_match_a    = channel_mode_reg[`FLD_A_MATCH_LO+1:`FLD_A_MATCH_LO];
  wire [1:0] line_a_on_limit      = channel_mode_reg[`FLD_A_LIMIT_LO+1:`FLD_A_LIMIT_LO];
  wire [1:0] line_a_on_event      = channel_mode_reg[`FLD_A_EVENT_LO+1:`FLD_A_EVENT_LO];
  wire [1:0] line_a_on_sw_trigger = channel_mode_reg[`FLD_A_SWTRIG_LO+1:`FLD_A_SWTRIG_LO];
  wire [1:0] line_b_on_match_b    = channel_mode_reg[`FLD_B_MATCH_LO+1:`FLD_B_MATCH_LO];
  wire [1:0] line_b_on_limit      = channel_mode_reg[`FLD_B_LIMIT_LO+1:`FLD_B_LIMIT_LO];
  wire [1:0] line_b_on_event      = channel_mode_reg[`FLD_B_EVENT_LO+1:`FLD_B_EVENT_LO];
  wire [1:0] line_b_on_sw_trigger = channel_mode_reg[`FLD_B_SWTRIG_LO+1:`FLD_B_SWTRIG_LO];

  // apb write takes effect on the completing access edge
  wire       wr_done = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
  wire       ctl_wr  = wr_done & (PADDR_I == `OFS_CONTROL);
  wire       sw_trig = ctl_wr & PWDATA_I[`CTL_SW_TRIGGER];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  pin_sync_edge u_ext0 (.clk_i(SYS_CLK_I), .rstn_i(RSTN_I), .pin_i(EXT_CLK_SIG_ZERO_I),
                        .level_o(ext0_lvl), .rise_o(ext0_rise), .fall_o(ext0_fall));
  pin_sync_edge u_ext1 (.clk_i(SYS_CLK_I), .rstn_i(RSTN_I), .pin_i(EXT_CLK_SIG_ONE_I),
                        .level_o(ext1_lvl), .rise_o(ext1_rise), .fall_o(ext1_fall));
  pin_sync_edge u_ext2 (.clk_i(SYS_CLK_I), .rstn_i(RSTN_I), .pin_i(EXT_CLK_SIG_TWO_I),
                        .level_o(ext2_lvl), .rise_o(ext2_rise), .fall_o(ext2_fall));
  pin_sync_edge u_la  (.clk_i(SYS_CLK_I), .rstn_i(RSTN_I), .pin_i(IO_LINE_A_I),
                       .level_o(la_lvl), .rise_o(la_rise), .fall_o(la_fall));
  pin_sync_edge u_lb  (.clk_i(SYS_CLK_I), .rstn_i(RSTN_I), .pin_i(IO_LINE_B_I),
                       .level_o(lb_lvl), .rise_o(lb_rise), .fall_o(lb_fall));

  ////////////////////////////////////////////////////////////////////////////
  // counting clock selection

  // pick the clock source level
  always @* begin
    case (count_clock_select)
      3'd0:    tap_level = prescale_reg[`TAP_DIV2];
      3'd1:    tap_level = prescale_reg[`TAP_DIV8];
      3'd2:    tap_level = prescale_reg[`TAP_DIV32];
      3'd3:    tap_level = prescale_reg[`TAP_DIV128];
      3'd4:    tap_level = prescale_reg[`TAP_DIV1024];
      3'd5:    tap_level = ext0_lvl;
      3'd6:    tap_level = ext1_lvl;
      default: tap_level = ext2_lvl;
    endcase
    // burst gating signal, high when ungated
    case (burst_select)
      2'd1:    burst_level = ext0_lvl;
      2'd2:    burst_level = ext1_lvl;
      2'd3:    burst_level = ext2_lvl;
      default: burst_level = 1'b1;
    endcase
  end

  // invert then gate; a rising edge of the result is a counting edge
  wire gated_level = (tap_level ^ count_edge_invert) & burst_level;
  wire clk_tick    = gated_level & ~gated_prev_reg;
  wire count_edge  = clk_tick & clk_enabled_reg & clk_running_reg;

  ////////////////////////////////////////////////////////////////////////////
  // events

  // external event source and edges
  always @* begin
    case (event_source_select)
      2'd1:    begin evt_rise = ext0_rise; evt_fall = ext0_fall; end
      2'd2:    begin evt_rise = ext1_rise; evt_fall = ext1_fall; end
      2'd3:    begin evt_rise = ext2_rise; evt_fall = ext2_fall; end
      default: begin evt_rise = lb_rise;  evt_fall = lb_fall;  end
    endcase
  end

  // capture trigger on line a or b
  wire trig_rise = trigger_source_select ? la_rise : lb_rise;
  wire trig_fall = trigger_source_select ? la_fall : lb_fall;
  wire cap_trig  = ~wave & edge_hit(edge_select, trig_rise, trig_fall);
  wire wave_evt  = wave & edge_hit(edge_select, evt_rise, evt_fall);
  wire ext_trig  = cap_trig | (wave_evt & event_restart_en);

  // captures on line a edges
  wire load_first  = ~wave & edge_hit(first_capture_edge_sel, la_rise, la_fall);
  wire load_second = ~wave & edge_hit(second_capture_edge_sel, la_rise, la_fall);

  // compares, taken on the counting edge after the one that reached the value
  wire limit_hit = count_edge & (count_reg == limit_reg);
  wire match_a   = wave & count_edge & (count_reg == first_capture_reg);
  wire match_b   = wave & count_edge & (count_reg == second_capture_reg);
  wire limit_trig = limit_hit & limit_match_restart_en;
  wire restart   = sw_trig | ext_trig | limit_trig;

  // clock stop and disable causes per mode
  wire stop_evt = stop_bit & (wave ? limit_hit : load_second);
  wire dis_evt  = disable_bit & (wave ? limit_hit : load_second);

  ////////////////////////////////////////////////////////////////////////////
  // next state of counter and clock control

  always @* begin
    count_next   = count_reg;
    running_next = clk_running_reg;
    enabled_next = clk_enabled_reg;
    if (count_edge)
      count_next = count_reg + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
    // a trigger resets the counter and starts the clock
    if (restart) begin
      count_next   = {CNT_WIDTH{1'b0}};
      running_next = 1'b1;
    end else if (stop_evt) begin
      running_next = 1'b0;
    end
    // enable command, disable command and disable event
    if (ctl_wr & PWDATA_I[`CTL_CLK_ENABLE])
      enabled_next = 1'b1;
    if ((ctl_wr & PWDATA_I[`CTL_CLK_DISABLE]) | dis_evt)
      enabled_next = 1'b0;
  end

  // waveform line levels; later assignments carry higher priority
  always @* begin
    line_a_next = IO_LINE_A_O;
    line_b_next = IO_LINE_B_O;
    if (wave) begin
      if (match_a)
        line_a_next = apply_action(line_a_on_match_a, line_a_next);
      if (match_b)
        line_b_next = apply_action(line_b_on_match_b, line_b_next);
      if (limit_hit) begin
        line_a_next = apply_action(line_a_on_limit, IO_LINE_A_O);
        line_b_next = apply_action(line_b_on_limit, IO_LINE_B_O);
      end
      if (wave_evt) begin
        line_a_next = apply_action(line_a_on_event, IO_LINE_A_O);
        line_b_next = apply_action(line_b_on_event, IO_LINE_B_O);
      end
      if (sw_trig) begin
        line_a_next = apply_action(line_a_on_sw_trigger, IO_LINE_A_O);
        line_b_next = apply_action(line_b_on_sw_trigger, IO_LINE_B_O);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, capture and pin registers

  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prescale_reg       <= {`PRESCALE_WIDTH{1'b0}};
      gated_prev_reg     <= 1'b0;
      count_reg          <= `RST_VALUE;
      clk_running_reg    <= 1'b0;
      clk_enabled_reg    <= 1'b0;
      first_capture_reg  <= `RST_VALUE;
      second_capture_reg <= `RST_VALUE;
      limit_reg          <= `RST_VALUE;
      IO_LINE_A_O        <= 1'b0;
      IO_LINE_A_OE_O     <= 1'b0;
      IO_LINE_B_O        <= 1'b0;
      IO_LINE_B_OE_O     <= 1'b0;
    end else begin
      prescale_reg    <= prescale_reg + {{(`PRESCALE_WIDTH-1){1'b0}}, 1'b1};
      gated_prev_reg  <= gated_level;
      count_reg       <= count_next;
      clk_running_reg <= running_next;
      clk_enabled_reg <= enabled_next;
      // hardware capture, only in capture mode
      if (load_first)
        first_capture_reg <= count_reg;
      // software writes to compare registers only in waveform mode
      else if (wr_done & wave & (PADDR_I == `OFS_FIRST_CAPTURE))
        first_capture_reg <= PWDATA_I[CNT_WIDTH-1:0];
      if (load_second)
        second_capture_reg <= count_reg;
      else if (wr_done & wave & (PADDR_I == `OFS_SECOND_CAPTURE))
        second_capture_reg <= PWDATA_I[CNT_WIDTH-1:0];
      if (wr_done & (PADDR_I == `OFS_LIMIT))
        limit_reg <= PWDATA_I[CNT_WIDTH-1:0];
      // line a driven in waveform mode; line b only if not the event source
      IO_LINE_A_O    <= line_a_next;
      IO_LINE_A_OE_O <= wave;
      IO_LINE_B_O    <= line_b_next;
      IO_LINE_B_OE_O <= wave & (event_source_select != 2'd0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  // mode register write
  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I)
      channel_mode_reg <= `RST_CHANNEL_MODE;
    else if (wr_done & (PADDR_I == `OFS_CHANNEL_MODE))
      channel_mode_reg <= PWDATA_I;
  end

  // read mux; unmapped addresses flag an error
  always @* begin
    rd_data = 32'h0000_0000;
    case (PADDR_I)
      `OFS_CONTROL:        rd_data = 32'h0000_0000;
      `OFS_CHANNEL_MODE:   rd_data = channel_mode_reg;
      `OFS_COUNT:          rd_data[CNT_WIDTH-1:0] = count_reg;
      `OFS_FIRST_CAPTURE:  rd_data[CNT_WIDTH-1:0] = first_capture_reg;
      `OFS_SECOND_CAPTURE: rd_data[CNT_WIDTH-1:0] = second_capture_reg;
      `OFS_LIMIT:          rd_data[CNT_WIDTH-1:0] = limit_reg;
      `OFS_STATUS: begin
        rd_data[`STS_CLK_ENABLED] = clk_enabled_reg;
        rd_data[`STS_CLK_RUNNING] = clk_running_reg;
        rd_data[`STS_LINE_A]      = la_lvl;
        rd_data[`STS_LINE_B]      = lb_lvl;
        rd_data[`STS_WAVE]        = wave;
      end
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  wire addr_ok = (PADDR_I == `OFS_CONTROL) | (PADDR_I == `OFS_CHANNEL_MODE) |
                 (PADDR_I == `OFS_COUNT) | (PADDR_I == `OFS_FIRST_CAPTURE) |
                 (PADDR_I == `OFS_SECOND_CAPTURE) | (PADDR_I == `OFS_LIMIT) |
                 (PADDR_I == `OFS_STATUS);

  // one wait state: pready rises in the second access cycle
  always @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else begin
      PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
      PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & ~addr_ok;
      if (PSEL_I & PENABLE_I & ~PREADY_O & ~PWRITE_I)
        PRDATA_O <= rd_data;
    end
  end

endmodule // timer_channel_mode_control

// ### verification/timer_channel_mode_control_bench.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
// apb-driven bench for the channel mode logic
module timer_channel_mode_control_bench;
  logic        clk = 0;       // master clock
  logic        rst_n = 0;     // reset, active low
  logic        psel = 0;      // apb select
  logic        penable = 0;   // apb access phase
  logic        pwrite = 0;    // apb direction
  logic [7:0]  paddr = 0;     // apb address
  logic [31:0] pwdata = 0;    // apb write data
  wire  [31:0] prdata;        // apb read data
  wire         pready, pslverr;
  logic [2:0]  ext = 0;       // external signal levels
  logic        la = 0, lb = 0; // far-side line levels
  wire  [2:0]  ext_w;
  wire         a_w, b_w, a_out, a_oe, b_out, b_oe;
  logic [31:0] rdat, cap;     // last read data, saved value
  logic        serr;          // last error flag
  int          failures = 0, total_checks = 0;
  logic [1:0]  acts [5] = '{2'd1, 2'd3, 2'd2, 2'd3, 2'd0}; // output actions
  logic [4:0]  lvl = 5'b11001; // line level after each action
  ////////////////////////////////////////////////////////////////
  // clock
  always #5 clk = ~clk;
  timer_channel_mode_control timer_channel_mode_control_inst (
    .SYS_CLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_CLK_SIG_ZERO_I(ext_w[0]),
    .EXT_CLK_SIG_ONE_I(ext_w[1]), .EXT_CLK_SIG_TWO_I(ext_w[2]), .IO_LINE_A_I(a_w),
    .IO_LINE_A_O(a_out), .IO_LINE_A_OE_O(a_oe), .IO_LINE_B_I(b_w),
    .IO_LINE_B_O(b_out), .IO_LINE_B_OE_O(b_oe));
  timer_pins_model timer_pins_model_inst (
    .ext_lvl_i(ext), .a_lvl_i(la), .b_lvl_i(lb), .a_o_i(a_out), .a_oe_i(a_oe),
    .b_o_i(b_out), .b_oe_i(b_oe), .ext_o(ext_w), .a_o(a_w), .b_o(b_w));
  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        final_report();
      end
      @(posedge clk);
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // ln: 0 line a, 1 line b, 2..4 external signal
  task automatic set_pin(input int ln, input logic v);
    if (ln == 0) la <= v;
    else if (ln == 1) lb <= v;
    else ext[ln - 2] <= v;
  endtask
  // run long, then rise and fall a pin; a trigger shows as a fresh count
  task automatic probe(input logic [31:0] m, input int ln, input logic [1:0] ed);
    wr(8'h04, m);
    wr(8'h00, 32'h5);
    for (int e = 0; e < 2; e++) begin
      tick(200);
      set_pin(ln, e == 0);
      tick(8);
      rd(8'h10);
      `CHK(rdat < 32'd30, ed[e])
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #600000;
    failures++;
    final_report();
  end
  // main sequence
  initial begin
    int div;
    tick(12);
    rst_n <= 1'b1;
    rd(8'h04);
    `CHK(rdat, 32'h0)
    rd(8'h08);
    `CHK({serr, rdat}, 33'h1_0000_0000)
    wr(8'h04, 32'ha5a5_d3c6);
    rd(8'h04);
    `CHK(rdat, 32'ha5a5_d3c6)
    // prescaled taps
    for (int c = 0; c < 5; c++) begin
      div = (c == 4) ? 1024 : 2 << (2 * c);
      wr(8'h04, 32'(c));
      wr(8'h00, 32'h5);
      tick(2048);
      rd(8'h10);
      `CHK(rdat + 32'd1 - 32'(2048 / div) <= 32'd5, 1'b1)
    end
    // external clocks, the middle one inverted
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, 32'(5 + i) | (i == 1 ? 32'h8 : 32'h0));
      wr(8'h00, 32'h5);
      ext[i] <= 1'b1;
      tick(8);
      rd(8'h10);
      `CHK(rdat, 32'(i != 1))
      ext[i] <= 1'b0;
      tick(8);
      rd(8'h10);
      `CHK(rdat, 32'h1)
    end
    // burst gating
    for (int b = 1; b < 4; b++) begin
      wr(8'h04, 32'(b) << 4);
      wr(8'h00, 32'h5);
      tick(40);
      rd(8'h10);
      `CHK(rdat, 32'h0)
      ext[b - 1] <= 1'b1;
      tick(40);
      rd(8'h10);
      `CHK(rdat > 32'd10, 1'b1)
      ext[b - 1] <= 1'b0;
    end
    // captures, then stop or disable on second load or on limit
    wr(8'h1c, 32'd50);
    for (int j = 0; j < 4; j++) begin
      wr(8'h04, (j > 1 ? 32'h8000 : 32'h0009_0000) | 32'h40 << j % 2);
      wr(8'h00, 32'h5);
      tick(20);
      la <= 1'b1;
      tick(20);
      la <= 1'b0;
      tick(150);
      rd(8'h14);
      cap = rdat;
      rd(8'h18);
      if (j < 2) `CHK(rdat - cap - 32'd9 <= 32'd2, 1'b1)
      rd(8'h10);
      cap = rdat;
      tick(10);
      rd(8'h10);
      `CHK(rdat, cap)
      rd(8'h20);
      `CHK(rdat[1 - j % 2], 1'b0)
    end
    // limit restart on and off
    wr(8'h04, 32'h4000);
    wr(8'h00, 32'h5);
    tick(300);
    rd(8'h10);
    `CHK(rdat <= 32'd50, 1'b1)
    wr(8'h04, 32'h0);
    tick(300);
    rd(8'h10);
    `CHK(rdat > 32'd50, 1'b1)
    // capture triggers: every edge code, then line a and a wrong line
    for (int c = 0; c < 4; c++)
      probe(32'(c) << 8, 1, 2'(c));
    probe(32'h0500, 0, 2'b01);
    probe(32'h0700, 1, 2'b00);
    // waveform events from every source
    for (int s = 0; s < 4; s++)
      probe(32'h9000 | 32'(s) << 10 | 32'(3 - s) << 8, s == 0 ? 1 : s + 1, 2'(3 - s));
    probe(32'h0010_8500, 2, 2'b00);
    `CHK(a_out, 1'b1)
    // software trigger actions on both lines
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, 32'h8400 | 32'(acts[i]) << 22 | 32'(acts[i]) << 30);
      wr(8'h00, 32'h4);
      tick(3);
      `CHK({a_out, b_out}, {2{lvl[i]}})
    end
    // compare then limit actions on both lines; the limit also stops the clock
    wr(8'h14, 32'd20);
    wr(8'h18, 32'd20);
    wr(8'h04, 32'h0f06_8440);
    wr(8'h00, 32'h5);
    tick(60);
    `CHK({a_out, b_out}, 2'b00)
    tick(100);
    `CHK({a_out, b_out}, 2'b11)
    // reset in mid-run returns mode and pins to their idle state
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    `CHK({a_out, b_out, a_oe, b_oe}, 4'h0)
    rd(8'h04);
    `CHK(rdat, 32'h0)
    final_report();
  end
endmodule // timer_channel_mode_control_bench

// ### verification/timer_channel_mode_control_properties.sv
`timescale 1ns/100ps
// bus and pin direction checks on the top ports
module timer_channel_mode_control_checker (
  input wire logic        SYS_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        IO_LINE_A_O,
  input wire logic        IO_LINE_A_OE_O,
  input wire logic        IO_LINE_B_O,
  input wire logic        IO_LINE_B_OE_O
);
  wire logic mapped; // address hits a register
  wire logic mode_wr; // completed mode write
  assign mapped = PADDR_I inside {8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  assign mode_wr = PREADY_O && PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h04;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  ////////////////////////////////////////////////////////////////
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready stood longer than one cycle");
  a_ready_one_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("ready not in second access cycle");
  a_error_unmapped: assert property (PREADY_O |-> PSLVERR_O == !mapped)
    else $error("error flag does not match address map");
  a_error_in_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error flag outside ready");
  a_line_a_dir: assert property (mode_wr |-> ##2 IO_LINE_A_OE_O == $past(PWDATA_I[15], 2))
    else $error("line a direction not set by mode");
  a_line_b_dir: assert property (mode_wr |-> ##2 IO_LINE_B_OE_O ==
      ($past(PWDATA_I[15], 2) && $past(PWDATA_I[11:10], 2) != 2'b00))
    else $error("line b direction not set by mode");
  a_capture_quiet_a: assert property (!IO_LINE_A_OE_O && !$past(IO_LINE_A_OE_O)
      |-> $stable(IO_LINE_A_O))
    else $error("line a moved in capture mode");
  a_capture_quiet_b: assert property (!IO_LINE_A_OE_O && !$past(IO_LINE_A_OE_O)
      |-> $stable(IO_LINE_B_O))
    else $error("line b moved in capture mode");
endmodule // timer_channel_mode_control_checker

bind timer_channel_mode_control timer_channel_mode_control_checker checker_inst (
  .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .IO_LINE_A_O(IO_LINE_A_O), .IO_LINE_A_OE_O(IO_LINE_A_OE_O),
  .IO_LINE_B_O(IO_LINE_B_O), .IO_LINE_B_OE_O(IO_LINE_B_OE_O));

// ### verification/timer_pins_model.sv
`timescale 1ns/100ps
// far side: external clock signals and the two io lines
module timer_pins_model (
  input  wire logic [2:0] ext_lvl_i, // levels of the external signals
  input  wire logic       a_lvl_i,   // far-side level on line a
  input  wire logic       b_lvl_i,   // far-side level on line b
  input  wire logic       a_o_i,     // design value on line a
  input  wire logic       a_oe_i,    // design drives line a
  input  wire logic       b_o_i,     // design value on line b
  input  wire logic       b_oe_i,    // design drives line b
  output wire logic [2:0] ext_o,     // external signals seen by design
  output wire logic       a_o,       // resolved line a
  output wire logic       b_o        // resolved line b
);
  // external signals stand still unless the bench moves them
  assign ext_o = ext_lvl_i;
  // the far side yields the line while the design drives it
  assign a_o = a_oe_i ? a_o_i : a_lvl_i;
  // line b is ours whenever the design leaves it an input
  assign b_o = b_oe_i ? b_o_i : b_lvl_i;
endmodule // timer_pins_model
